// ### dv/mei_assertions.sv
// checker of register read-back and power outputs of the motion event block
`timescale 1ns/1ns
module mei_checker
  import mei_pkg::*;
(
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // power controls
  input wire mei_power_t o_power
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  AST_STANDBY_AT_START: assert property ($rose(i_rst_n) |-> !o_power.measure)
    else $error("measure set on reset release");
  AST_IMPACT_UPPER_ZERO: assert property (
    i_reg_rd && i_reg_addr == ADDR_IMPACT_AXIS_SELECT |=> o_reg_rdata[7:4] == 4'h0)
    else $error("impact select upper bits not zero");
  AST_STATUS_TOP_ZERO: assert property (
    i_reg_rd && i_reg_addr == ADDR_EVENT_AXIS_STATUS |=> !o_reg_rdata[7])
    else $error("status bit 7 not zero");
  AST_RATE_UPPER_ZERO: assert property (
    i_reg_rd && i_reg_addr == ADDR_OUTPUT_RATE_CONTROL |=> o_reg_rdata[7:5] == 3'h0)
    else $error("rate register upper bits not zero");
  AST_RATE_MIRROR: assert property (
    i_reg_rd && !i_reg_wr && !$past(i_reg_wr) && i_reg_addr == ADDR_OUTPUT_RATE_CONTROL
    |=> o_reg_rdata[4:0] == {o_power.low_power, o_power.rate})
    else $error("rate outputs differ from register");
  AST_POWER_MIRROR: assert property (
    i_reg_rd && !i_reg_wr && !$past(i_reg_wr) && i_reg_addr == ADDR_POWER_MODE_CONTROL
    |=> o_reg_rdata[3] == o_power.measure && o_reg_rdata[1:0] == o_power.wake_rate)
    else $error("power outputs differ from register");
  AST_SLEEP_NO_FIFO: assert property (o_power.sleeping |-> !o_power.fifo_write_en)
    else $error("fifo written while sleeping");
  AST_DATA_READ_ZERO: assert property (
    i_reg_rd && i_reg_addr >= ADDR_DATA_FIRST && i_reg_addr <= ADDR_DATA_LAST
    |=> o_reg_rdata == 8'h00)
    else $error("data register read not zero");
endmodule

bind mei_top mei_checker u_checker (
  .i_clock     (i_clock),
  .i_rst_n     (i_rst_n),
  .i_reg_addr  (i_reg_addr),
  .i_reg_wr    (i_reg_wr),
  .i_reg_rd    (i_reg_rd),
  .o_reg_rdata (o_reg_rdata),
  .o_power     (o_power)
);

// ### dv/mei_host_model.sv
// host model driving the register port of the motion event block
`timescale 1ns/1ns
module mei_host_model
  import mei_pkg::*;
(
  // clock
  input  wire logic       i_clock,
  // register port
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic      [7:0] o_reg_wdata,
  output logic            o_reg_rd,
  input  wire logic [7:0] i_reg_rdata
);
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd    = 1'b0;
  end

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = 1'b1;
    @(posedge i_clock);
    #1;
    o_reg_wr    = 1'b0;
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_reg_addr = a;
    o_reg_rd   = 1'b1;
    @(posedge i_clock);
    #1;
    o_reg_rd   = 1'b0;
    o_reg_addr = ~a;
    @(posedge i_clock);
    #1;
    d = i_reg_rdata;
  endtask

  // standby with the old setting, new setting in standby, then measure
  task automatic set_power(input logic [7:0] v);
    logic [7:0] cur;
    read(ADDR_POWER_MODE_CONTROL, cur);
    write(ADDR_POWER_MODE_CONTROL, cur & 8'hf7);
    write(ADDR_POWER_MODE_CONTROL, v & 8'hf7);
    write(ADDR_POWER_MODE_CONTROL, v);
  endtask
endmodule

// ### dv/test_motion_event_irq_power_control.sv
// testbench of the motion event irq and power control block
`timescale 1ns/1ns
module test_motion_event_irq_power_control import mei_pkg::*;;
  logic        i_clock, i_rst_n, wr, rd, tk, wm, ovr, pol, line_a, line_b;
  logic [7:0]  addr, wdata, rdata;
  logic [2:0]  act_en, still_en;
  logic [15:0] dur;
  mei_sense_t  sense;
  mei_power_t  pwr;
  int          errors, total_checks;

  mei_host_model HOST (.i_clock(i_clock), .o_reg_addr(addr), .o_reg_wr(wr),
    .o_reg_wdata(wdata), .o_reg_rd(rd), .i_reg_rdata(rdata));
  mei_top #(.SLEEP_BASE_CYCLES(10)) DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_sample_tick(tk), .i_sense(sense),
    .i_activity_axis_enable(act_en), .i_stillness_axis_enable(still_en),
    .i_stillness_duration(dur), .i_watermark_event(wm), .i_overrun_event(ovr),
    .i_irq_active_low(pol), .o_power(pwr), .o_irq_line_a(line_a), .o_irq_line_b(line_b));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    HOST.read(a, v);
    check(v & m, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge i_clock);
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clock);
      #1;
      tk = 1'b1;
      @(posedge i_clock);
      #1;
      tk = 1'b0;
    end
    settle();
  endtask
  task automatic imp(input logic dbl);
    @(posedge i_clock);
    #1;
    sense.impact_single = !dbl;
    sense.impact_double = dbl;
    @(posedge i_clock);
    #1;
    sense.impact_single = 1'b0;
    sense.impact_double = 1'b0;
    settle();
  endtask
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic s_regs();
    logic [7:0] a [5] = '{ADDR_IMPACT_AXIS_SELECT, ADDR_OUTPUT_RATE_CONTROL,
      ADDR_POWER_MODE_CONTROL, ADDR_IRQ_ENABLE_MASK, ADDR_IRQ_ROUTING_SELECT};
    logic [7:0] r [5] = '{8'h00, 8'h0a, 8'h00, 8'h00, 8'h00};
    logic [7:0] m [5] = '{8'h07, 8'h17, 8'h37, 8'hf3, 8'hf3};
    for (int i = 0; i < 5; i++) begin
      rdchk(a[i], 8'hff, r[i]);
      HOST.write(a[i], 8'hf7);
      rdchk(a[i], 8'hff, m[i]);
      HOST.write(a[i], r[i]);
    end
    rdchk(ADDR_IRQ_CAUSE_FLAGS, IRQ_IMPL_MASK, 8'h02);
  endtask

  task automatic s_activity();
    HOST.write(ADDR_IRQ_ENABLE_MASK, 8'h10);
    HOST.set_power(8'h08);
    act_en = 3'b110;
    sense.act_over = 3'b001;
    tick(1);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h10, 8'h00);
    sense.act_over = 3'b011;
    tick(1);
    check({6'h00, line_b, line_a}, 8'h01);
    rdchk(ADDR_EVENT_AXIS_STATUS, 8'h70, 8'h20);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h10, 8'h10);
    sense.act_over = 3'b000;
    tick(1);
    rdchk(ADDR_EVENT_AXIS_STATUS, 8'h70, 8'h20);
    HOST.write(ADDR_IRQ_ROUTING_SELECT, 8'h10);
    act_en = 3'b100;
    sense.act_over = 3'b110;
    tick(1);
    check({6'h00, line_b, line_a}, 8'h02);
    pol = 1'b1;
    settle();
    check({6'h00, line_b, line_a}, 8'h01);
    rdchk(ADDR_EVENT_AXIS_STATUS, 8'h70, 8'h40);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h80, 8'h80);
    pol = 1'b0;
    rdchk(ADDR_DATA_FIRST, 8'hff, 8'h00);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h83, 8'h00);
    HOST.write(ADDR_IRQ_ENABLE_MASK, 8'h01);
    HOST.write(ADDR_IRQ_ROUTING_SELECT, 8'h00);
    ovr = 1'b1;
    @(posedge i_clock);
    #1;
    ovr = 1'b0;
    settle();
    check({6'h00, line_b, line_a}, 8'h01);
    rdchk(ADDR_DATA_LAST, 8'hff, 8'h00);
  endtask

  task automatic s_impact();
    HOST.write(ADDR_IMPACT_AXIS_SELECT, 8'h07);
    HOST.write(ADDR_IRQ_ENABLE_MASK, 8'h60);
    HOST.write(ADDR_IRQ_ROUTING_SELECT, 8'h40);
    sense.impact_over = 3'b101;
    imp(1'b0);
    check({6'h00, line_b, line_a}, 8'h02);
    rdchk(ADDR_EVENT_AXIS_STATUS, 8'h07, 8'h05);
    HOST.write(ADDR_IMPACT_AXIS_SELECT, 8'h06);
    imp(1'b1);
    check({6'h00, line_b, line_a}, 8'h03);
    rdchk(ADDR_EVENT_AXIS_STATUS, 8'h07, 8'h04);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h60, 8'h60);
    settle();
    check({6'h00, line_b, line_a}, 8'h00);
    HOST.write(ADDR_IMPACT_AXIS_SELECT, 8'h0e);
    imp(1'b0);
    sense.in_latency = 1'b1;
    @(posedge i_clock);
    #1;
    sense.in_latency = 1'b0;
    imp(1'b1);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h60, 8'h40);
  endtask

  task automatic s_link();
    int n;
    HOST.write(ADDR_IRQ_ENABLE_MASK, 8'h18);
    HOST.set_power(8'h38);
    act_en = 3'b111;
    still_en = 3'b111;
    dur = 16'h0002;
    sense.act_over = 3'b111;
    sense.still_under = 3'b011;
    tick(4);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h18, 8'h00);
    sense.act_over = 3'b000;
    sense.still_under = 3'b111;
    tick(4);
    check({7'h00, pwr.sleeping}, 8'h01);
    check({7'h00, pwr.fifo_write_en}, 8'h00);
    rdchk(ADDR_EVENT_AXIS_STATUS, 8'h08, 8'h08);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h18, 8'h08);
    sense.act_over = 3'b111;
    sense.still_under = 3'b000;
    for (n = 0; n < 100 && pwr.sleeping !== 1'b0; n++) begin
      tick(1);
    end
    check({7'h00, pwr.sleeping}, 8'h00);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h10, 8'h10);
    sense.act_over = 3'b000;
    HOST.set_power(8'h08);
  endtask

  task automatic s_sleep();
    int cnt;
    rdchk(ADDR_DATA_FIRST, 8'hff, 8'h00);
    for (int w = 0; w < 4; w++) begin
      HOST.set_power(8'h0c | 8'(w));
      cnt = 0;
      repeat (160) begin
        @(posedge i_clock);
        #1;
        cnt += int'(pwr.output_update);
      end
      check(8'(cnt >= (16 >> w) - 1 && cnt <= (16 >> w) + 1), 8'h01);
    end
    tick(2);
    imp(1'b0);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h60, 8'h00);
    check({7'h00, pwr.fifo_write_en}, 8'h00);
    rdchk(ADDR_IRQ_CAUSE_FLAGS, 8'h80, 8'h00);
    rdchk(ADDR_EVENT_AXIS_STATUS, 8'h08, 8'h00);
    HOST.set_power(8'h08);
  endtask

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  initial begin
    errors = 0;
    total_checks = 0;
    i_rst_n = 1'b0;
    {tk, wm, ovr, pol} = 4'h0;
    {act_en, still_en} = 6'h00;
    dur = 16'h0000;
    sense = '0;
    repeat (20) @(posedge i_clock);
    #1;
    i_rst_n = 1'b1;
    s_regs();
    s_activity();
    s_impact();
    s_link();
    s_sleep();
    end_of_test();
  end
endmodule

// ### hdl/mei_top.sv
// motion event irq and power control: axis selection, link/sleep sequencing, irq flags and lines
`timescale 1ns/1ns
module mei_top
  import mei_pkg::*;
#(
  parameter int SLEEP_BASE_CYCLES = SLEEP_BASE_CYC,
  parameter int DUR_W             = 16
) (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  // register port from the serial front end
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_rd,
  output logic      [7:0]        o_reg_rdata,
  // sensing datapath
  input  wire logic              i_sample_tick,
  input  wire mei_sense_t        i_sense,
  input  wire logic [2:0]        i_activity_axis_enable,
  input  wire logic [2:0]        i_stillness_axis_enable,
  input  wire logic [DUR_W-1:0]  i_stillness_duration,
  input  wire logic              i_watermark_event,
  input  wire logic              i_overrun_event,
  input  wire logic              i_irq_active_low,
  // power control and interrupt lines
  output mei_power_t             o_power,
  output logic                   o_irq_line_a,
  output logic                   o_irq_line_b
);

  typedef enum logic {LINK_SEEK_STILL, LINK_SEEK_ACT} mei_link_t;

  logic [7:0]       impact_sel_q;
  logic [7:0]       rate_ctl_q;
  logic [7:0]       power_mode_control_q;
  logic [7:0]       irq_enable_q;
  logic [7:0]       irq_route_q;
  logic [7:0]       cause_q;
  logic [2:0]       act_flags_q;
  logic [2:0]       imp_flags_q;
  logic             asleep_q;
  logic             cancel_q;
  logic             still_done_q;
  logic [DUR_W-1:0] still_cnt_q;
  logic [25:0]      sleep_cnt_q;
  logic [3:0]       sleep_div_q;
  logic             sleep_tick_q;
  mei_link_t        link_q;
  mei_power_t       power_q;
  logic             line_a_q;
  logic             line_b_q;
  logic [7:0]       rdata_q;

  logic       wr_hit;
  logic       act_en;
  logic       still_en;
  logic       linked;
  logic       auto_doze;
  logic       measure;
  logic       sleeping;
  logic       tick;
  logic       act_armed;
  logic       still_armed;
  logic       act_event;
  logic       still_event;
  logic       all_still;
  logic       single_event;
  logic       double_event;
  logic [2:0] imp_axes;
  logic       data_read;
  logic       cause_read;
  logic [7:0] cause_set;
  logic [7:0] cause_clr;
  logic [7:0] irq_active;
  logic [3:0] wake_div;
  logic       impact_ok;
  logic       still_met;
  logic       sample_event;
  logic       line_a_req;
  logic       line_b_req;
  logic [7:0] status_byte;

  assign wr_hit    = i_reg_wr;
  assign measure   = power_mode_control_q[PWR_MEASURE_BIT];
  assign linked    = power_mode_control_q[PWR_LINK_BIT];
  assign auto_doze = linked & power_mode_control_q[PWR_AUTODOZE_BIT];
  // manual sleep bit or automatic doze
  assign sleeping  = power_mode_control_q[PWR_SLEEP_BIT] | asleep_q;
  assign imp_axes  = impact_sel_q[IMP_AXES_LSB +: 3];

  // function enables from axis participation
  assign act_en   = |i_activity_axis_enable;
  assign still_en = |i_stillness_axis_enable;

  // sample tick: normal rate from datapath, wakeup rate while sleeping
  assign tick = measure & (sleeping ? sleep_tick_q : i_sample_tick);

  // link sequencing decides which detector is armed
  always_comb begin
    act_armed   = act_en;
    still_armed = still_en & ~sleeping;
    if (linked && act_en && still_en) begin
      act_armed   = (link_q == LINK_SEEK_ACT);
      still_armed = still_armed & (link_q == LINK_SEEK_STILL);
    end
  end

  assign act_event = tick & act_armed
                     & |(i_sense.act_over & i_activity_axis_enable);
  assign all_still = &(i_sense.still_under | ~i_stillness_axis_enable);
  assign still_event = tick & still_armed & all_still & ~still_done_q
                       & still_met;

  // stillness duration reached, counted in samples
  assign still_met = still_cnt_q >= i_stillness_duration;

  // only activity runs while sleeping, so impacts are ignored then
  assign impact_ok = measure & ~sleeping;

  assign single_event = impact_ok & i_sense.impact_single
                        & |(i_sense.impact_over & imp_axes);
  assign double_event = impact_ok & i_sense.impact_double & ~cancel_q
                        & |imp_axes;

  // stillness duration counter over samples
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !still_armed) begin
      still_cnt_q  <= '0;
      still_done_q <= 1'b0;
    end else if (tick) begin
      if (!all_still) begin
        still_cnt_q  <= '0;
        still_done_q <= 1'b0;
      end else begin
        if (still_cnt_q != {DUR_W{1'b1}}) begin
          still_cnt_q <= still_cnt_q + 1'b1;
        end
        if (still_event) begin
          still_done_q <= 1'b1;
        end
      end
    end
  end

  // link state
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      link_q <= LINK_SEEK_STILL;
    end else if (!linked || !act_en || !still_en) begin
      // sequencing restarts by seeking stillness once both are enabled again
      link_q <= LINK_SEEK_STILL;
    end else if (still_event) begin
      link_q <= LINK_SEEK_ACT;
    end else if (act_event) begin
      link_q <= LINK_SEEK_STILL;
    end
  end

  // automatic sleep state
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      asleep_q <= 1'b0;
    end else if (auto_doze) begin
      if (still_event) begin
        asleep_q <= 1'b1;
      end else if (act_event) begin
        asleep_q <= 1'b0;
      end
    end
  end

  // double impact cancel when over threshold in latency
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cancel_q <= 1'b0;
    end else if (i_sense.impact_single || i_sense.impact_double) begin
      cancel_q <= 1'b0;
    end else if (!impact_sel_q[IMP_SUPPRESS_BIT]) begin
      // a cancel left over from an earlier suppress setting is dropped
      cancel_q <= 1'b0;
    end else if (impact_sel_q[IMP_SUPPRESS_BIT] && i_sense.in_latency
                 && |(i_sense.impact_over & imp_axes)) begin
      cancel_q <= 1'b1;
    end
  end

  // event-axis flags: every enabled axis over threshold at the event, overwritten per event
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      act_flags_q <= 3'h0;
      imp_flags_q <= 3'h0;
    end else begin
      if (act_event) begin
        act_flags_q <= i_sense.act_over & i_activity_axis_enable;
      end
      if (single_event || double_event) begin
        imp_flags_q <= i_sense.impact_over & imp_axes;
      end
    end
  end

  // sleep sampling divider: 8 Hz base, then divided by 1, 2, 4, 8
  assign wake_div = 4'h1 << power_mode_control_q[PWR_WAKE_LSB +: PWR_WAKE_W];

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !sleeping) begin
      sleep_cnt_q  <= '0;
      sleep_div_q  <= 4'h0;
      sleep_tick_q <= 1'b0;
    end else begin
      sleep_tick_q <= 1'b0;
      if (sleep_cnt_q >= 26'(SLEEP_BASE_CYCLES - 1)) begin
        sleep_cnt_q <= '0;
        if (sleep_div_q >= wake_div - 4'h1) begin
          sleep_div_q  <= 4'h0;
          sleep_tick_q <= 1'b1;
        end else begin
          sleep_div_q <= sleep_div_q + 4'h1;
        end
      end else begin
        sleep_cnt_q <= sleep_cnt_q + 26'h1;
      end
    end
  end

  // control register writes
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      impact_sel_q <= RST_IMPACT_AXIS_SELECT;
      rate_ctl_q   <= RST_OUTPUT_RATE_CONTROL;
      power_mode_control_q  <= RST_POWER_MODE_CONTROL;
      irq_enable_q <= RST_IRQ_ENABLE_MASK;
      irq_route_q  <= RST_IRQ_ROUTING_SELECT;
    end else if (wr_hit) begin
      unique case (i_reg_addr)
        ADDR_IMPACT_AXIS_SELECT:  impact_sel_q <= i_reg_wdata & 8'h0f;
        ADDR_OUTPUT_RATE_CONTROL: rate_ctl_q   <= i_reg_wdata & 8'h1f;
        ADDR_POWER_MODE_CONTROL:  power_mode_control_q  <= i_reg_wdata & 8'h3f;
        ADDR_IRQ_ENABLE_MASK:     irq_enable_q <= i_reg_wdata & IRQ_IMPL_MASK;
        ADDR_IRQ_ROUTING_SELECT:  irq_route_q  <= i_reg_wdata & IRQ_IMPL_MASK;
        default: ;
      endcase
    end
  end

  // cause flags: set wins over clear
  assign data_read  = i_reg_rd && (i_reg_addr >= ADDR_DATA_FIRST)
                      && (i_reg_addr <= ADDR_DATA_LAST);
  assign cause_read = i_reg_rd && (i_reg_addr == ADDR_IRQ_CAUSE_FLAGS);

  // sample-ready is held back while sleeping
  assign sample_event = tick & ~sleeping;

  always_comb begin
    cause_set = 8'h00;
    cause_set[IRQ_SAMPLE_BIT]    = sample_event;
    cause_set[IRQ_SINGLE_BIT]    = single_event;
    cause_set[IRQ_DOUBLE_BIT]    = double_event;
    cause_set[IRQ_ACTIVITY_BIT]  = act_event;
    cause_set[IRQ_STILLNESS_BIT] = still_event;
    cause_set[IRQ_WATERMARK_BIT] = i_watermark_event;
    cause_set[IRQ_OVERRUN_BIT]   = i_overrun_event;
    cause_clr = 8'h00;
    if (data_read) begin
      cause_clr[IRQ_SAMPLE_BIT]    = 1'b1;
      cause_clr[IRQ_WATERMARK_BIT] = 1'b1;
      cause_clr[IRQ_OVERRUN_BIT]   = 1'b1;
    end
    if (cause_read) begin
      cause_clr[IRQ_SINGLE_BIT]    = 1'b1;
      cause_clr[IRQ_DOUBLE_BIT]    = 1'b1;
      cause_clr[IRQ_ACTIVITY_BIT]  = 1'b1;
      cause_clr[IRQ_STILLNESS_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cause_q <= RST_IRQ_CAUSE_FLAGS;
    end else begin
      cause_q <= ((cause_q & ~cause_clr) | cause_set) & IRQ_IMPL_MASK;
    end
  end

  // interrupt lines
  assign irq_active = cause_q & irq_enable_q;
  assign line_a_req = |(irq_active & ~irq_route_q);
  assign line_b_req = |(irq_active & irq_route_q);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      line_a_q <= 1'b0;
      line_b_q <= 1'b0;
    end else begin
      line_a_q <= line_a_req ^ i_irq_active_low;
      line_b_q <= line_b_req ^ i_irq_active_low;
    end
  end

  assign o_irq_line_a = line_a_q;
  assign o_irq_line_b = line_b_q;

  // power outputs to datapath
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      power_q <= '0;
    end else begin
      power_q.measure       <= measure;
      power_q.low_power     <= rate_ctl_q[LOW_POWER_BIT];
      power_q.rate          <= rate_ctl_q[RATE_LSB +: RATE_W];
      power_q.sleeping      <= sleeping;
      power_q.wake_rate     <= power_mode_control_q[PWR_WAKE_LSB +: PWR_WAKE_W];
      power_q.fifo_write_en <= measure & ~sleeping;
      power_q.output_update <= tick;
    end
  end

  assign o_power = power_q;

  // event axis status byte
  always_comb begin
    status_byte                   = 8'h00;
    status_byte[STS_ACT_LSB +: 3] = act_flags_q;
    status_byte[STS_ASLEEP_BIT]   = asleep_q;
    status_byte[STS_IMP_LSB +: 3] = imp_flags_q;
  end

  // register read data
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_IMPACT_AXIS_SELECT:  rdata_q <= impact_sel_q;
        ADDR_EVENT_AXIS_STATUS:   rdata_q <= status_byte;
        ADDR_OUTPUT_RATE_CONTROL: rdata_q <= rate_ctl_q;
        ADDR_POWER_MODE_CONTROL:  rdata_q <= power_mode_control_q;
        ADDR_IRQ_ENABLE_MASK:     rdata_q <= irq_enable_q;
        ADDR_IRQ_ROUTING_SELECT:  rdata_q <= irq_route_q;
        ADDR_IRQ_CAUSE_FLAGS:     rdata_q <= cause_q;
        default:                  rdata_q <= 8'h00;
      endcase
    end
  end

  assign o_reg_rdata = rdata_q;

endmodule

// ### pkg/mei_pkg.sv
// constants, register map and carrier types of the motion event irq and power control block
package mei_pkg;

  // register offsets
  localparam logic [7:0] ADDR_IMPACT_AXIS_SELECT  = 8'h2a;
  localparam logic [7:0] ADDR_EVENT_AXIS_STATUS   = 8'h2b;
  localparam logic [7:0] ADDR_OUTPUT_RATE_CONTROL = 8'h2c;
  localparam logic [7:0] ADDR_POWER_MODE_CONTROL  = 8'h2d;
  localparam logic [7:0] ADDR_IRQ_ENABLE_MASK     = 8'h2e;
  localparam logic [7:0] ADDR_IRQ_ROUTING_SELECT  = 8'h2f;
  localparam logic [7:0] ADDR_IRQ_CAUSE_FLAGS     = 8'h30;
  localparam logic [7:0] ADDR_DATA_FIRST          = 8'h32;
  localparam logic [7:0] ADDR_DATA_LAST           = 8'h37;

  // reset values
  localparam logic [7:0] RST_IMPACT_AXIS_SELECT  = 8'h00;
  localparam logic [7:0] RST_OUTPUT_RATE_CONTROL = 8'h0a;
  localparam logic [7:0] RST_POWER_MODE_CONTROL  = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE_MASK     = 8'h00;
  localparam logic [7:0] RST_IRQ_ROUTING_SELECT  = 8'h00;
  localparam logic [7:0] RST_IRQ_CAUSE_FLAGS     = 8'h02;

  // impact axis select fields
  localparam int IMP_SUPPRESS_BIT = 3;
  localparam int IMP_AXES_LSB     = 0;

  // event axis status fields
  localparam int STS_ACT_LSB    = 4;
  localparam int STS_ASLEEP_BIT = 3;
  localparam int STS_IMP_LSB    = 0;

  // output rate control fields
  localparam int RATE_LSB      = 0;
  localparam int RATE_W        = 4;
  localparam int LOW_POWER_BIT = 4;

  // power mode control fields
  localparam int PWR_LINK_BIT    = 5;
  localparam int PWR_AUTODOZE_BIT = 4;
  localparam int PWR_MEASURE_BIT = 3;
  localparam int PWR_SLEEP_BIT   = 2;
  localparam int PWR_WAKE_LSB    = 0;
  localparam int PWR_WAKE_W      = 2;

  // irq enable / routing / cause bit positions
  localparam int IRQ_SAMPLE_BIT    = 7;
  localparam int IRQ_SINGLE_BIT    = 6;
  localparam int IRQ_DOUBLE_BIT    = 5;
  localparam int IRQ_ACTIVITY_BIT  = 4;
  localparam int IRQ_STILLNESS_BIT = 3;
  localparam int IRQ_WATERMARK_BIT = 1;
  localparam int IRQ_OVERRUN_BIT   = 0;
  localparam logic [7:0] IRQ_IMPL_MASK = 8'hfb;

  // timing: sleep sampling base rate
  localparam int CLOCK_HZ       = 25_000_000;
  localparam int SLEEP_BASE_HZ  = 8;
  localparam int SLEEP_BASE_CYC = CLOCK_HZ / SLEEP_BASE_HZ;

  // per-axis comparator results and impact sequencing from the sensing datapath
  typedef struct packed {
    logic [2:0] act_over;
    logic [2:0] still_under;
    logic [2:0] impact_over;
    logic       impact_single;
    logic       impact_double;
    logic       in_latency;
  } mei_sense_t;

  // power and sampling controls to the sensing datapath
  typedef struct packed {
    logic                  measure;
    logic                  low_power;
    logic [RATE_W-1:0]     rate;
    logic                  sleeping;
    logic [PWR_WAKE_W-1:0] wake_rate;
    logic                  fifo_write_en;
    logic                  output_update;
  } mei_power_t;

endpackage
